// File: rtl/fifo_port_device.sv
`timescale 1ns/10ps
`include "fifo_port_cfg.svh"

module fifo_port_device
	import fifo_port_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               srst,
	fifo_port_if.device             link,
	input  wire logic [`DATA_W-1:0] rx_in_data,
	input  wire logic               rx_in_valid,
	output logic                    rx_in_ready,
	output logic      [`DATA_W-1:0] tx_out_data,
	output logic                    tx_out_valid,
	input  wire logic               tx_out_ready,
	input  wire logic               suspended,
	input  wire logic               wake_enabled,
	output logic                    resume_req,
	output logic                    flush_req
);
	logic [3:0]          div_q;      // Divider for the interface clock
	logic [3:0]          div_d;
	logic                clk_q;      // Interface clock level
	logic                clk_d;
	logic                rise;       // Edge of interface clock this cycle
	logic                fall;       // Falling edge of interface clock this cycle
	logic [`DATA_W-1:0]  rx_head;    // Head of receive buffer
	logic                rx_valid;
	logic                rx_pop;
	logic                tx_ready;
	logic                tx_push;
	logic                rxf_n_q;    // Registered status flags
	logic                rxf_n_d;
	logic                txe_n_q;
	logic                txe_n_d;
	logic [`DATA_W-1:0]  dout_q;     // Registered bus drive
	logic [`DATA_W-1:0]  dout_d;
	logic                doe_q;
	logic                doe_d;
	logic                pwr_q;
	logic                pwr_d;
	logic                resume_q;
	logic                resume_d;
	logic                flush_q;
	logic                flush_d;
	logic                send_now_wake_n_prev_q; // Strobe level at previous edge
	logic                send_now_wake_n_prev_d;
	logic [3:0]          rx_cnt_q;   // Mirror of receive buffer fill
	logic [3:0]          rx_cnt_d;
	logic [3:0]          tx_cnt_q;   // Mirror of transmit buffer fill
	logic [3:0]          tx_cnt_d;
	logic                rx_push;    // Byte enters receive buffer
	logic                tx_pop;     // Byte leaves transmit buffer

	// Fill after one edge; both buffer mirrors use the same step
	// Kept here because the buffers do not export their counts
	function automatic logic [3:0] fill_step(
		input logic [3:0] cnt,
		input logic       up,
		input logic       down
	);
		logic [3:0] nxt; // Fill after this edge
		nxt = cnt;
		if (up && !down) begin
			nxt = cnt + 4'h1;
		end else if (down && !up) begin
			nxt = cnt - 4'h1;
		end
		return nxt;
	endfunction : fill_step

	// Device makes the link clock itself, so edges are known internally
	assign rise = (div_q == `CLK_HALF_CYC - 4'h1) && !clk_q;
	// Falling edge sits mid-way between two transfer edges
	assign fall = (div_q == `CLK_HALF_CYC - 4'h1) && clk_q;

	// Accepted moves on the far sides of the two buffers
	assign rx_push = rx_in_valid && rx_in_ready;
	assign tx_pop  = tx_out_valid && tx_out_ready;

	// Transfers happen only at interface clock rising edges
	assign rx_pop  = rise && !rxf_n_q && !link.rd_strobe_n;
	assign tx_push = rise && !txe_n_q && !link.wr_strobe_n;

	// Receive buffer: data from the USB side toward the master
	byte_fifo u_rx_buf (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.in_data   (rx_in_data),
		.in_valid  (rx_in_valid),
		.in_ready  (rx_in_ready),
		.out_data  (rx_head),
		.out_valid (rx_valid),
		.out_ready (rx_pop)
	);

	// Transmit buffer: master bytes toward the USB side; full stalls master
	byte_fifo u_tx_buf (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.in_data   (link.fifo_data_bus),
		.in_valid  (tx_push),
		.in_ready  (tx_ready),
		.out_data  (tx_out_data),
		.out_valid (tx_out_valid),
		.out_ready (tx_out_ready)
	);

	// Next values for clock, flags, bus and sideband
	always_comb begin
		div_d       = div_q;
		clk_d       = clk_q;
		rxf_n_d     = rxf_n_q;
		txe_n_d     = txe_n_q;
		send_now_wake_n_prev_d = send_now_wake_n_prev_q;
		resume_d    = 1'b0;
		flush_d     = 1'b0;
		pwr_d       = suspended;
		// Buffer fill mirrors track every accepted move on either side
		rx_cnt_d    = fill_step(rx_cnt_q, rx_push, rx_pop && rx_valid);
		tx_cnt_d    = fill_step(tx_cnt_q, tx_push && tx_ready, tx_pop);
		// Free-running divider; flip the clock every half period
		// Limitation: the link period is fixed at eight system clocks
		if (div_q == `CLK_HALF_CYC - 4'h1) begin
			div_d = 4'h0;
			clk_d = !clk_q;
		end else begin
			div_d = div_q + 4'h1;
		end
		// Status flags refresh at each rising edge, so master sees them stable
		if (rise) begin
			// Flags show the fill after this edge's own moves; the master picks
			// its next strobe from this value, and a stale one would lose a byte
			rxf_n_d     = (rx_cnt_d == 4'h0);
			txe_n_d     = (tx_cnt_d == 4'(`BUF_DEPTH));
			send_now_wake_n_prev_d = link.send_now_wake_n;
			// Falling strobe selects wake or flush by power state
			if (send_now_wake_n_prev_q && !link.send_now_wake_n) begin
				if (pwr_q && wake_enabled) begin
					resume_d = 1'b1;
				end else if (!pwr_q) begin
					flush_d = 1'b1;
				end
			end
		end
		// Head byte moves to the bus at falling link edges only, so it stands
		// across the rising edge that takes it and the master reads it later
		dout_d = fall ? rx_head : dout_q;
		// Drive the bus only while the master holds enable low
		doe_d = !link.out_enable_n;
	end

	// Register the link pins and the resume/flush requests so they come straight from flops
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			div_q       <= 4'h0;
			clk_q       <= 1'b0;
			rxf_n_q     <= 1'b1;
			txe_n_q     <= 1'b1;
			dout_q      <= 8'h00;
			doe_q       <= 1'b0;
			pwr_q       <= 1'b0;
			resume_q    <= 1'b0;
			flush_q     <= 1'b0;
			send_now_wake_n_prev_q <= 1'b1;
			// Both buffers start empty
			rx_cnt_q    <= 4'h0;
			tx_cnt_q    <= 4'h0;
		end else begin
			div_q       <= div_d;
			clk_q       <= clk_d;
			rxf_n_q     <= rxf_n_d;
			txe_n_q     <= txe_n_d;
			dout_q      <= dout_d;
			doe_q       <= doe_d;
			pwr_q       <= pwr_d;
			resume_q    <= resume_d;
			flush_q     <= flush_d;
			send_now_wake_n_prev_q <= send_now_wake_n_prev_d;
			rx_cnt_q    <= rx_cnt_d;
			tx_cnt_q    <= tx_cnt_d;
		end
	end

	// Link pins come straight from the registers above
	assign link.interface_clock_out = clk_q;
	assign link.rx_data_avail_n     = rxf_n_q;
	assign link.tx_space_avail_n    = txe_n_q;
	assign link.power_enable_n      = pwr_q;
	assign link.dev_data_o          = dout_q;
	assign link.dev_data_oe         = doe_q;
	assign resume_req               = resume_q;
	assign flush_req                = flush_q;
endmodule : fifo_port_device

// File: rtl/fifo_port_cfg.svh
`ifndef FIFO_PORT_CFG_SVH
`define FIFO_PORT_CFG_SVH

// Byte width of the parallel data bus
`define DATA_W          8
// Depth of each buffer in the data path
`define BUF_DEPTH       8
// Pointer width for the buffer depth
`define BUF_PTR_W       3
// Interface clock half period in system clocks (device divider)
`define CLK_HALF_CYC    4'h4
// Interface clock period, ns, and turn-around time in interface periods
`define LINK_PERIOD_NS  400
`define TURN_PERIODS    1
// Length of the send-now / wake strobe, in interface clocks
`define STROBE_CYC      2'h1

`endif

// File: rtl/fifo_port_pkg.sv
package fifo_port_pkg;

	// Device transfer direction as seen by the master
	typedef enum logic [1:0] {
		M_IDLE  = 2'b00,
		M_TURN  = 2'b01,
		M_READ  = 2'b10,
		M_WRITE = 2'b11
	} master_state_t;

	// Link clock phase seen by the sampler
	typedef enum logic [1:0] {
		EDGE_NONE = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10
	} edge_t;

endpackage : fifo_port_pkg

// File: rtl/fifo_port_if.sv
`timescale 1ns/10ps
`include "fifo_port_cfg.svh"

// Parallel FIFO link between the bridge device and its master
interface fifo_port_if;
	logic                  interface_clock_out; // Clock made by the device
	logic                  tx_space_avail_n;    // Low when transmit buffer has room
	logic                  rx_data_avail_n;     // Low when receive byte waits
	logic                  rd_strobe_n;         // Read strobe from master
	logic                  wr_strobe_n;         // Write strobe from master
	logic                  out_enable_n;        // Master lets the device drive data
	logic                  send_now_wake_n;     // Send-immediate / wake strobe
	logic                  power_enable_n;      // High while suspended
	logic [`DATA_W-1:0]    dev_data_o;          // Device data drive value
	logic                  dev_data_oe;         // Device drives the bus
	logic [`DATA_W-1:0]    mst_data_o;          // Master data drive value
	logic                  mst_data_oe;         // Master drives the bus
	logic [`DATA_W-1:0]    fifo_data_bus;       // Resolved bus level

	// Resolve the shared bus from the two enables; idle bus reads as zero
	assign fifo_data_bus = dev_data_oe ? dev_data_o :
	                       (mst_data_oe ? mst_data_o : {`DATA_W{1'b0}});

	modport device (
		output interface_clock_out, tx_space_avail_n, rx_data_avail_n,
		output power_enable_n, dev_data_o, dev_data_oe,
		input  rd_strobe_n, wr_strobe_n, out_enable_n, send_now_wake_n, fifo_data_bus
	);

	modport master (
		input  interface_clock_out, tx_space_avail_n, rx_data_avail_n,
		input  power_enable_n, fifo_data_bus,
		output rd_strobe_n, wr_strobe_n, out_enable_n, send_now_wake_n,
		output mst_data_o, mst_data_oe
	);
endinterface : fifo_port_if

// File: rtl/byte_fifo.sv
`timescale 1ns/10ps
`include "fifo_port_cfg.svh"

// Small synchronous FIFO with valid/ready on both sides
module byte_fifo #(
	parameter int WIDTH = `DATA_W,
	parameter int DEPTH = `BUF_DEPTH,
	parameter int PTR_W = `BUF_PTR_W
) (
	input  wire logic             sys_clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	logic [WIDTH-1:0] mem_q [DEPTH];  // Storage words
	logic [PTR_W-1:0] wr_ptr_q;       // Write pointer
	logic [PTR_W-1:0] wr_ptr_d;
	logic [PTR_W-1:0] rd_ptr_q;       // Read pointer
	logic [PTR_W-1:0] rd_ptr_d;
	logic [PTR_W:0]   count_q;        // Words held
	logic [PTR_W:0]   count_d;
	logic             push;
	logic             pop;

	// Full and empty are honest: taken from the word count
	assign in_ready  = (count_q != DEPTH[PTR_W:0]);
	assign out_valid = (count_q != '0);
	assign out_data  = mem_q[rd_ptr_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer and count next values
	always_comb begin
		wr_ptr_d = push ? PTR_W'(wr_ptr_q + 1'b1) : wr_ptr_q;
		rd_ptr_d = pop ? PTR_W'(rd_ptr_q + 1'b1) : rd_ptr_q;
		count_d  = count_q;
		if (push && !pop) begin
			count_d = (PTR_W+1)'(count_q + 1'b1);
		end else if (pop && !push) begin
			count_d = (PTR_W+1)'(count_q - 1'b1);
		end
	end

	// Register pointers; memory has no reset since count guards it
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q  <= count_d;
		end
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end
endmodule : byte_fifo

// File: rtl/fifo_port_master.sv
`timescale 1ns/10ps
`include "fifo_port_cfg.svh"

// Master end: reads bytes to a user stream and writes bytes from one
module fifo_port_master
	import fifo_port_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               srst,
	fifo_port_if.master             link,
	input  wire logic [`DATA_W-1:0] wr_data,
	input  wire logic               wr_valid,
	output logic                    wr_ready,
	output logic      [`DATA_W-1:0] rd_data,
	output logic                    rd_valid,
	input  wire logic               send_now
);
	logic [2:0]          clk_sync_q;  // Three-stage sampler for link clock
	logic [2:0]          clk_sync_d;
	logic [2:0]          rxf_sync_q;
	logic [2:0]          txe_sync_q;
	logic                clk_seen_q;  // Agreed clock level
	logic                clk_seen_d;
	edge_t               edge_s;
	master_state_t       st_q;
	master_state_t       st_d;
	logic                rd_n_q, rd_n_d;
	logic                wr_n_q, wr_n_d;
	logic                oe_n_q, oe_n_d;
	logic                send_now_wake_n_n_q, send_now_wake_n_n_d;
	logic [`DATA_W-1:0]  dout_q, dout_d;
	logic                doe_q, doe_d;
	logic [`DATA_W-1:0]  rdat_q, rdat_d;
	logic                rval_q, rval_d;
	logic                wrdy_q, wrdy_d;

	// Rising or falling edge once second and third stages agree on a new level
	always_comb begin
		clk_sync_d = {clk_sync_q[1:0], link.interface_clock_out};
		clk_seen_d = clk_seen_q;
		edge_s     = EDGE_NONE;
		if (clk_sync_q[2] == clk_sync_q[1] && clk_sync_q[2] != clk_seen_q) begin
			clk_seen_d = clk_sync_q[2];
			edge_s     = clk_sync_q[2] ? EDGE_RISE : EDGE_FALL;
		end
	end

	// Strobes change where the master sees the link rise, which lands on the
	// device's falling edge, half a period before the device samples them
	always_comb begin
		st_d     = st_q;
		rd_n_d   = rd_n_q;
		wr_n_d   = wr_n_q;
		oe_n_d   = oe_n_q;
		send_now_wake_n_n_d = send_now_wake_n_n_q;
		dout_d   = dout_q;
		doe_d    = doe_q;
		rdat_d   = rdat_q;
		rval_d   = 1'b0;
		wrdy_d   = 1'b0;
		if (edge_s == EDGE_RISE) begin
			// Read strobe was low at the last transfer edge and was chosen from
			// the flag the device used there, so that byte moved
			if (!rd_n_q) begin
				rdat_d = link.fifo_data_bus;
				rval_d = 1'b1;
			end
			send_now_wake_n_n_d = !send_now;
			rd_n_d   = 1'b1;
			wr_n_d   = 1'b1;
			doe_d    = 1'b0;
			case (st_q)
				M_IDLE: begin
					oe_n_d = 1'b1;
					if (!rxf_sync_q[2]) begin
						oe_n_d = 1'b0;
						st_d   = M_TURN;
					end else if (wr_valid && !txe_sync_q[2]) begin
						st_d = M_WRITE;
					end
				end
				M_TURN: begin
					if (!rxf_sync_q[2]) begin
						rd_n_d = 1'b0;
						st_d   = M_READ;
					end else begin
						oe_n_d = 1'b1;
						st_d   = M_IDLE;
					end
				end
				M_READ: begin
					if (!rxf_sync_q[2]) begin
						rd_n_d = 1'b0;
					end else begin
						oe_n_d = 1'b1;
						st_d   = M_IDLE;
					end
				end
				M_WRITE: begin
					if (wr_valid && !txe_sync_q[2]) begin
						wr_n_d = 1'b0;
						doe_d  = 1'b1;
						dout_d = wr_data;
						wrdy_d = 1'b1;
					end else begin
						st_d = M_IDLE;
					end
				end
				default: st_d = M_IDLE;
			endcase
		end
	end

	// Register all state
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			clk_sync_q <= 3'h0;
			rxf_sync_q <= 3'h7;
			txe_sync_q <= 3'h7;
			clk_seen_q <= 1'b0;
			st_q       <= M_IDLE;
			rd_n_q     <= 1'b1;
			wr_n_q     <= 1'b1;
			oe_n_q     <= 1'b1;
			send_now_wake_n_n_q   <= 1'b1;
			dout_q     <= 8'h00;
			doe_q      <= 1'b0;
			rdat_q     <= 8'h00;
			rval_q     <= 1'b0;
			wrdy_q     <= 1'b0;
		end else begin
			clk_sync_q <= clk_sync_d;
			rxf_sync_q <= {rxf_sync_q[1:0], link.rx_data_avail_n};
			txe_sync_q <= {txe_sync_q[1:0], link.tx_space_avail_n};
			clk_seen_q <= clk_seen_d;
			st_q       <= st_d;
			rd_n_q     <= rd_n_d;
			wr_n_q     <= wr_n_d;
			oe_n_q     <= oe_n_d;
			send_now_wake_n_n_q   <= send_now_wake_n_n_d;
			dout_q     <= dout_d;
			doe_q      <= doe_d;
			rdat_q     <= rdat_d;
			rval_q     <= rval_d;
			wrdy_q     <= wrdy_d;
		end
	end

	assign link.rd_strobe_n     = rd_n_q;
	assign link.wr_strobe_n     = wr_n_q;
	assign link.out_enable_n    = oe_n_q;
	assign link.send_now_wake_n = send_now_wake_n_n_q;
	assign link.mst_data_o      = dout_q;
	assign link.mst_data_oe     = doe_q;
	assign rd_data              = rdat_q;
	assign rd_valid             = rval_q;
	assign wr_ready             = wrdy_q;
endmodule : fifo_port_master

// File: test/fifo_port_properties.sv
`timescale 1ns/10ps

// Link checker; sees only the shared wires between the two ends
module fifo_port_properties (
	input logic sys_clk,             // System clock
	input logic srst,                // Synchronous reset
	input logic interface_clock_out, // Divided link clock
	input logic rd_strobe_n,         // Read strobe
	input logic wr_strobe_n,         // Write strobe
	input logic out_enable_n,        // Bus turn-around control
	input logic dev_data_oe,         // Device drives the bus
	input logic mst_data_oe          // Master drives the bus
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	// Each link clock half lasts four system clocks
	sequence s_high_half;
		interface_clock_out [*4] ##1 !interface_clock_out;
	endsequence
	sequence s_low_half;
		!interface_clock_out [*4] ##1 interface_clock_out;
	endsequence
	// Read phase: bus handed over and strobe low
	sequence s_read_phase;
		!out_enable_n && !rd_strobe_n;
	endsequence

	property p_clk_high;
		$rose(interface_clock_out) |-> s_high_half;
	endproperty
	property p_clk_low;
		$fell(interface_clock_out) |-> s_low_half;
	endproperty
	property p_oe_drive;
		dev_data_oe |-> !$past(out_enable_n);
	endproperty
	property p_no_contend;
		!(dev_data_oe && mst_data_oe);
	endproperty
	property p_strobes_apart;
		!(!rd_strobe_n && !wr_strobe_n);
	endproperty
	// Turn-around: enable already low one link period back
	property p_oe_lead;
		$fell(rd_strobe_n) |-> !$past(out_enable_n, 8);
	endproperty
	property p_wr_stands;
		$fell(wr_strobe_n) |-> !wr_strobe_n [*8];
	endproperty
	property p_read_drive;
		s_read_phase |-> dev_data_oe;
	endproperty
	property p_write_drive;
		!wr_strobe_n |-> mst_data_oe;
	endproperty

	a_clk_high: assert property (p_clk_high)
		else $error("link clock high half has wrong length");
	a_clk_low: assert property (p_clk_low)
		else $error("link clock low half has wrong length");
	a_oe_drive: assert property (p_oe_drive)
		else $error("device drives bus without enable");
	a_no_contend: assert property (p_no_contend)
		else $error("both ends drive the bus");
	a_strobes_apart: assert property (p_strobes_apart)
		else $error("read and write strobes low together");
	a_oe_lead: assert property (p_oe_lead)
		else $error("read strobe without turn-around period");
	a_wr_stands: assert property (p_wr_stands)
		else $error("write strobe shorter than a link period");
	a_read_drive: assert property (p_read_drive)
		else $error("device silent during read");
	a_write_drive: assert property (p_write_drive)
		else $error("master silent during write");
endmodule : fifo_port_properties

// File: test/sync_fifo_parallel_port_test.sv
`timescale 1ns/10ps
`include "fifo_port_cfg.svh"

module sync_fifo_parallel_port_test;
	logic               sys_clk;      // 20 MHz system clock
	logic               srst;         // Reset, active high
	logic [`DATA_W-1:0] rx_in_data;   // Bytes toward the master
	logic               rx_in_valid;
	logic               rx_in_ready;
	logic [`DATA_W-1:0] tx_out_data;  // Bytes from the master
	logic               tx_out_valid;
	logic               tx_out_ready;
	logic               suspended;
	logic               wake_enabled;
	logic               resume_req;
	logic               flush_req;
	logic [`DATA_W-1:0] wr_data;
	logic               wr_valid;
	logic               wr_ready;
	logic [`DATA_W-1:0] rd_data;
	logic               rd_valid;
	logic               send_now;
	logic [7:0]         d [10];       // Write pattern
	logic [7:0]         r [10];       // Read pattern
	int                 bad_count;
	int                 total_checks;

	fifo_port_if link ();

	fifo_port_device i_fifo_port_device (
		.sys_clk      (sys_clk),
		.srst         (srst),
		.link         (link),
		.rx_in_data   (rx_in_data),
		.rx_in_valid  (rx_in_valid),
		.rx_in_ready  (rx_in_ready),
		.tx_out_data  (tx_out_data),
		.tx_out_valid (tx_out_valid),
		.tx_out_ready (tx_out_ready),
		.suspended    (suspended),
		.wake_enabled (wake_enabled),
		.resume_req   (resume_req),
		.flush_req    (flush_req)
	);

	fifo_port_master i_fifo_port_master (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.link     (link),
		.wr_data  (wr_data),
		.wr_valid (wr_valid),
		.wr_ready (wr_ready),
		.rd_data  (rd_data),
		.rd_valid (rd_valid),
		.send_now (send_now)
	);

	fifo_port_properties i_fifo_port_properties (
		.sys_clk             (sys_clk),
		.srst                (srst),
		.interface_clock_out (link.interface_clock_out),
		.rd_strobe_n         (link.rd_strobe_n),
		.wr_strobe_n         (link.wr_strobe_n),
		.out_enable_n        (link.out_enable_n),
		.dev_data_oe         (link.dev_data_oe),
		.mst_data_oe         (link.mst_data_oe)
	);

	// Compare one value; an unknown never matches
	task check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up

	// Quiet link after reset: room to write, nothing to read
	task t_idle;
		repeat (40) @(negedge sys_clk);
		check(8'(link.tx_space_avail_n), 8'h00);
		check(8'(link.rx_data_avail_n), 8'h01);
		check(8'(link.power_enable_n), 8'h00);
	endtask : t_idle

	// Writes stall at eight bytes while the far side holds off, then drain in order
	task t_write_fill;
		int i;
		int j;
		int n;
		i = 0;
		j = 0;
		tx_out_ready = 1'b0;
		for (n = 0; n < 900 && j < 10; n++) begin
			@(negedge sys_clk);
			if (n == 300) begin
				check(8'(i), 8'h08);
				check(8'(link.tx_space_avail_n), 8'h01);
				tx_out_ready = 1'b1;
			end
			if (wr_ready) i++;
			wr_data = (i < 10) ? d[i] : 8'h00;
			wr_valid = (i < 10);
			// Head byte stays until a system clock with tx_out_ready high pops it
			if (tx_out_valid && tx_out_ready) begin
				check(tx_out_data, d[j]);
				j++;
			end
		end
		check(8'(j), 8'h0A);
		wr_valid = 1'b0;
	endtask : t_write_fill

	// Stream of ten bytes must reach the master whole and in order
	task t_read_stream;
		int  k;
		int  m;
		int  n;
		logic push;
		k = 0;
		m = 0;
		push = 1'b0;
		for (n = 0; n < 900 && m < 10; n++) begin
			@(negedge sys_clk);
			if (push) k++;
			rx_in_data = (k < 10) ? r[k] : 8'h00;
			rx_in_valid = (k < 10);
			#1 push = rx_in_valid && rx_in_ready;
			if (rd_valid) begin
				check(rd_data, r[m]);
				m++;
			end
		end
		check(8'(m), 8'h0A);
		rx_in_valid = 1'b0;
	endtask : t_read_stream

	// Strobe meaning depends on suspend state and wake permission
	task t_send_strobe;
		logic [3:0] tbl [3];
		logic       fl;
		logic       rs;
		int         c;
		int         n;
		// Columns: suspended, wake enabled, flush expected, resume expected
		tbl = '{4'b0010, 4'b1101, 4'b1000};
		for (c = 0; c < 3; c++) begin
			suspended = tbl[c][3];
			wake_enabled = tbl[c][2];
			repeat (40) @(negedge sys_clk);
			check(8'(link.power_enable_n), 8'(tbl[c][3]));
			send_now = 1'b1;
			fl = 1'b0;
			rs = 1'b0;
			for (n = 0; n < 120; n++) begin
				@(negedge sys_clk);
				if (n == 24) send_now = 1'b0;
				fl = fl | flush_req;
				rs = rs | resume_req;
			end
			check(8'(fl), 8'(tbl[c][1]));
			check(8'(rs), 8'(tbl[c][0]));
		end
		suspended = 1'b0;
	endtask : t_send_strobe

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// Watchdog: the whole sequence needs well under five thousand cycles
	initial begin
		#250000;
		bad_count++;
		wrap_up();
	end

	initial begin
		bad_count = 0;
		total_checks = 0;
		for (int n = 0; n < 10; n++) begin
			d[n] = 8'hC0 + 8'(n);
			r[n] = 8'h3F - 8'(n);
		end
		srst = 1'b1;
		rx_in_data = 8'h00;
		rx_in_valid = 1'b0;
		tx_out_ready = 1'b0;
		suspended = 1'b0;
		wake_enabled = 1'b0;
		wr_data = 8'h00;
		wr_valid = 1'b0;
		send_now = 1'b0;
		repeat (10) @(negedge sys_clk);
		srst = 1'b0;
		t_idle();
		t_write_fill();
		t_read_stream();
		t_send_strobe();
		wrap_up();
	end
endmodule : sync_fifo_parallel_port_test
